/* File: core/sof_pkg.sv */
// package for the serial output format configuration bank
// shared by the register bank top and its pin synchroniser; one clock domain
package sof_pkg;

	// register indices as numbered on the serial port, byte address is 4x
	localparam int SOF_ADDR_W = 8;
	localparam logic [SOF_ADDR_W-1:0] SOF_IDX_FMT = 8'h0d;
	localparam logic [SOF_ADDR_W-1:0] SOF_IDX_DRV = 8'h10;
	localparam logic [SOF_ADDR_W-1:0] SOF_ADDR_CTRL = 8'h00;
	localparam logic [SOF_ADDR_W-1:0] SOF_ADDR_STAT = 8'h04;
	localparam logic [SOF_ADDR_W-1:0] SOF_ADDR_FMT = 8'(SOF_IDX_FMT * 4);
	localparam logic [SOF_ADDR_W-1:0] SOF_ADDR_DRV = 8'(SOF_IDX_DRV * 4);

	localparam int SOF_REG_W = 11;
	localparam int SOF_DATA_W = 32;

	// output_format_control fields
	localparam int SOF_F_TWO_WIRE = 0;
	localparam int SOF_F_SDR = 1;
	localparam int SOF_F_SER16 = 2;
	localparam int SOF_F_RISING = 4;
	localparam int SOF_F_COARSE = 5;
	localparam int SOF_F_LSB = 6;
	localparam int SOF_F_BITWISE = 7;
	localparam int SOF_F_OVRD = 10;
	localparam logic [SOF_REG_W-1:0] SOF_FMT_MASK = 11'h4f7;
	localparam logic [SOF_REG_W-1:0] SOF_FMT_RESET = 11'h000;

	// lvds_drive_control fields
	localparam int SOF_D_DATA_DBL = 0;
	localparam int SOF_D_CLK_DBL = 1;
	localparam int SOF_D_DATA_CUR_LO = 2;
	localparam int SOF_D_CLK_CUR_LO = 4;
	localparam int SOF_D_TERM_LO = 6;
	localparam int SOF_CUR_W = 2;
	localparam int SOF_TERM_W = 5;
	localparam logic [SOF_REG_W-1:0] SOF_DRV_MASK = 11'h7ff;
	localparam logic [SOF_REG_W-1:0] SOF_DRV_RESET = 11'h000;

	// control register: self-clearing software reset
	localparam int SOF_C_SWRST = 10;

	// status register layout: effective format in low bits
	localparam int SOF_S_OVRD = 8;

	// output_drive_current encodings
	localparam logic [SOF_CUR_W-1:0] SOF_CUR_3P5MA = 2'h0;
	localparam logic [SOF_CUR_W-1:0] SOF_CUR_4MA = 2'h1;
	localparam logic [SOF_CUR_W-1:0] SOF_CUR_2P5MA = 2'h2;
	localparam logic [SOF_CUR_W-1:0] SOF_CUR_3MA = 2'h3;

	// clock output termination, one-hot legs combine in parallel
	localparam logic [SOF_TERM_W-1:0] SOF_TERM_NONE = 5'h00;
	localparam logic [SOF_TERM_W-1:0] SOF_TERM_166 = 5'h01;

	// ahb-lite codes
	localparam logic [1:0] SOF_HTRANS_NONSEQ = 2'h2;
	localparam logic SOF_HRESP_OKAY = 1'b0;

	// format functions, either from register or from parallel pins
	typedef struct packed {
		logic bit_wise;
		logic lsb_first;
		logic coarse_gain;
		logic capture_rising;
		logic serial_16;
		logic sdr_clock;
		logic two_wire;
	} sof_fmt_t;

	typedef struct packed {
		logic [SOF_TERM_W-1:0] clock_termination;
		logic [SOF_CUR_W-1:0] clock_drive_current;
		logic [SOF_CUR_W-1:0] output_drive_current;
		logic clock_current_double;
		logic data_current_double;
	} sof_drive_t;

	localparam int SOF_FMT_W = $bits(sof_fmt_t);

endpackage : sof_pkg

/* File: core/sof_sync.sv */
// two-flop synchroniser for a group of level inputs
// assumes levels that change slowly relative to CLK, no bus coherence needed
`timescale 1ns/1ns
`default_nettype none
module sof_sync
	import sof_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_q;

	always_comb
	begin
		next_meta = d;
		next_q = meta;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			meta <= '0;
			q <= '0;
		end
		else
		begin
			meta <= next_meta;
			q <= next_q;
		end
	end

endmodule : sof_sync
`default_nettype wire

/* File: core/sof_bank.sv */
// serial output format and lvds drive configuration bank, ahb-lite slave
// assumes one CLK domain, parallel format pins asynchronous to it
`timescale 1ns/1ns
`default_nettype none

module sof_bank
	import sof_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET,
	input wire logic HSEL,
	input wire logic [SOF_DATA_W-1:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [SOF_DATA_W-1:0] HWDATA,
	input wire logic HREADY,
	output logic [SOF_DATA_W-1:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire sof_fmt_t FORMAT_PINS,
	output sof_fmt_t FORMAT_OUT,
	output sof_drive_t DRIVE_OUT
);

	// bus and register state
	logic wr_pending;
	logic [SOF_ADDR_W-1:0] wr_addr;
	logic [SOF_REG_W-1:0] fmt_reg;
	logic [SOF_REG_W-1:0] drv_reg;
	logic next_wr_pending;
	logic [SOF_ADDR_W-1:0] next_wr_addr;
	logic [SOF_REG_W-1:0] next_fmt_reg;
	logic [SOF_REG_W-1:0] next_drv_reg;
	logic [SOF_DATA_W-1:0] next_hrdata;
	logic next_hreadyout;
	logic next_hresp;
	logic accept;

	// effective configuration state
	sof_fmt_t pins_sync;
	sof_fmt_t src;
	sof_fmt_t next_format;
	sof_drive_t next_drive;

	sof_sync #(
		.WIDTH(SOF_FMT_W)
	) u_pin_sync (
		.clk(CLK),
		.reset(RESET),
		.d(FORMAT_PINS),
		.q(pins_sync)
	);

	// only single word transfers are issued; size is not checked
	assign accept = HSEL && HREADY && (HTRANS == SOF_HTRANS_NONSEQ);

	always_comb
	begin
		next_fmt_reg = fmt_reg;
		next_drv_reg = drv_reg;
		next_wr_pending = accept && HWRITE;
		next_wr_addr = accept ? HADDR[SOF_ADDR_W-1:0] : wr_addr;
		next_hreadyout = 1'b1;
		next_hresp = SOF_HRESP_OKAY;
		next_hrdata = '0;
		if (wr_pending)
		begin
			unique case (wr_addr)
				SOF_ADDR_FMT:
				begin
					// unused bits are dropped even if host sets them
					next_fmt_reg = HWDATA[SOF_REG_W-1:0] & SOF_FMT_MASK;
				end
				SOF_ADDR_DRV:
				begin
					next_drv_reg = HWDATA[SOF_REG_W-1:0] & SOF_DRV_MASK;
				end
				SOF_ADDR_CTRL:
				begin
					if (HWDATA[SOF_C_SWRST])
					begin
						// bit is never stored, so it reads back 0
						next_fmt_reg = SOF_FMT_RESET;
						next_drv_reg = SOF_DRV_RESET;
					end
				end
				default:
				begin
					next_fmt_reg = fmt_reg;
				end
			endcase
		end
		// read of the next format and drive values so a read right after a write to them sees it
		if (accept && !HWRITE)
		begin
			unique case (HADDR[SOF_ADDR_W-1:0])
				SOF_ADDR_FMT:
				begin
					next_hrdata[SOF_REG_W-1:0] = next_fmt_reg;
				end
				SOF_ADDR_DRV:
				begin
					next_hrdata[SOF_REG_W-1:0] = next_drv_reg;
				end
				SOF_ADDR_STAT:
				begin
					next_hrdata[SOF_FMT_W-1:0] = FORMAT_OUT;
					next_hrdata[SOF_S_OVRD] = fmt_reg[SOF_F_OVRD];
				end
				default:
				begin
					next_hrdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			wr_pending <= 1'b0;
			wr_addr <= '0;
			fmt_reg <= SOF_FMT_RESET;
			drv_reg <= SOF_DRV_RESET;
			HRDATA <= '0;
			HREADYOUT <= 1'b1;
			HRESP <= SOF_HRESP_OKAY;
		end
		else
		begin
			wr_pending <= next_wr_pending;
			wr_addr <= next_wr_addr;
			fmt_reg <= next_fmt_reg;
			drv_reg <= next_drv_reg;
			HRDATA <= next_hrdata;
			HREADYOUT <= next_hreadyout;
			HRESP <= next_hresp;
		end
	end

	// source select between register and synchronised pins
	always_comb
	begin
		if (fmt_reg[SOF_F_OVRD])
		begin
			src.two_wire = fmt_reg[SOF_F_TWO_WIRE];
			src.sdr_clock = fmt_reg[SOF_F_SDR];
			src.serial_16 = fmt_reg[SOF_F_SER16];
			src.capture_rising = fmt_reg[SOF_F_RISING];
			src.coarse_gain = fmt_reg[SOF_F_COARSE];
			src.lsb_first = fmt_reg[SOF_F_LSB];
			src.bit_wise = fmt_reg[SOF_F_BITWISE];
		end
		else
		begin
			src = pins_sync;
		end
	end

	always_comb
	begin
		next_format.two_wire = src.two_wire;
		// ddr is forced in one-wire mode
		next_format.sdr_clock = src.two_wire && src.sdr_clock;
		next_format.serial_16 = src.serial_16;
		// edge choice is meaningless with ddr, report falling then
		next_format.capture_rising = next_format.sdr_clock
			&& src.capture_rising;
		next_format.coarse_gain = src.coarse_gain;
		next_format.lsb_first = src.lsb_first;
		next_format.bit_wise = src.two_wire && src.bit_wise;
		next_drive.data_current_double = drv_reg[SOF_D_DATA_DBL];
		next_drive.clock_current_double = drv_reg[SOF_D_CLK_DBL];
		next_drive.output_drive_current =
			drv_reg[SOF_D_DATA_CUR_LO +: SOF_CUR_W];
		next_drive.clock_drive_current =
			drv_reg[SOF_D_CLK_CUR_LO +: SOF_CUR_W];
		next_drive.clock_termination =
			drv_reg[SOF_D_TERM_LO +: SOF_TERM_W];
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			FORMAT_OUT <= '0;
			DRIVE_OUT <= '0;
		end
		else
		begin
			FORMAT_OUT <= next_format;
			DRIVE_OUT <= next_drive;
		end
	end

endmodule : sof_bank
`default_nettype wire

/* File: tb/sof_bank_chk.sv */
// bus and output relations of the format bank
// bound to sof_bank, one clock, synchronous reset
`timescale 1ns/1ns
`default_nettype none
module sof_bank_chk
	import sof_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET,
	input wire logic HSEL,
	input wire logic [SOF_DATA_W-1:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [SOF_DATA_W-1:0] HWDATA,
	input wire logic HREADY,
	input wire logic [SOF_DATA_W-1:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire sof_fmt_t FORMAT_OUT,
	input wire sof_drive_t DRIVE_OUT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	logic go;
	logic wr;
	assign go = HSEL && HREADY && HTRANS == SOF_HTRANS_NONSEQ;
	assign wr = go && HWRITE;
	AST_SDR_TWO: assert property (!FORMAT_OUT.two_wire |->
		!FORMAT_OUT.sdr_clock) else $error("sdr without two wires");
	AST_CAPT_SDR: assert property (!FORMAT_OUT.sdr_clock |->
		!FORMAT_OUT.capture_rising) else $error("edge without sdr");
	AST_BITW_TWO: assert property (!FORMAT_OUT.two_wire |->
		!FORMAT_OUT.bit_wise) else $error("bit-wise without two wires");
	AST_DRV_CAUSE: assert property (!$stable(DRIVE_OUT) |->
		$past(wr, 2) || $past(wr, 3) || $past(wr, 4))
		else $error("drive moved without a write");
	AST_SWRST: assert property (wr && HADDR[7:0] == SOF_ADDR_CTRL
		##1 HWDATA[SOF_C_SWRST] |-> ##[1:3] DRIVE_OUT == '0)
		else $error("soft reset left drive set");
	AST_UNMAP: assert property (go && !HWRITE && HADDR[7:0] == 8'h08
		|=> HRDATA == '0) else $error("unmapped read not zero");
	AST_RD_IDLE: assert property (!(go && !HWRITE) |=> HRDATA == '0)
		else $error("read data outside data phase");
	AST_UPPER: assert property (HRDATA[31:SOF_REG_W] == '0)
		else $error("upper read bits set");
	AST_BUS_OKAY: assert property (HREADYOUT && HRESP == SOF_HRESP_OKAY)
		else $error("bus not ready or not okay");
endmodule : sof_bank_chk
bind sof_bank sof_bank_chk u_chk (
	.CLK(CLK),
	.RESET(RESET),
	.HSEL(HSEL),
	.HADDR(HADDR),
	.HTRANS(HTRANS),
	.HWRITE(HWRITE),
	.HWDATA(HWDATA),
	.HREADY(HREADY),
	.HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT),
	.HRESP(HRESP),
	.FORMAT_OUT(FORMAT_OUT),
	.DRIVE_OUT(DRIVE_OUT)
);
`default_nettype wire

/* File: tb/sof_host.sv */
// host model: ahb-lite single word master
// every transfer starts at a rising edge, waits for HREADY
`timescale 1ns/1ns
`default_nettype none
module sof_host
	import sof_pkg::*;
(
	input wire logic CLK,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	output logic HSEL,
	output logic [31:0] HADDR,
	output logic [1:0] HTRANS,
	output logic HWRITE,
	output logic [2:0] HSIZE,
	output logic [31:0] HWDATA
);
	initial {HSEL, HADDR, HTRANS, HWRITE, HSIZE, HWDATA} = {36'h0, 3'h2, 32'h0};
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge CLK);
		HSEL <= 1'b1;
		HADDR <= {24'h0, a};
		HTRANS <= SOF_HTRANS_NONSEQ;
		HWRITE <= w;
		// address phase stands until ready is seen at a rising edge
		do
		begin
			@(posedge CLK);
		end while (HREADY !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= a == SOF_ADDR_FMT ? d & ~32'h308 : d;
		do
		begin
			@(posedge CLK);
		end while (HREADY !== 1'b1);
		// read here, before the edge's own updates land
		q = HRDATA;
	endtask : xfer
endmodule : sof_host
`default_nettype wire

/* File: tb/serial_output_format_config_tb.sv */
// bench for the format and drive configuration bank
// host model drives the bus, the bench drives the format pins
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module serial_output_format_config_tb
	import sof_pkg::*;
;
	logic CLK = 1'b0;
	logic RESET = 1'b1;
	logic HSEL, HWRITE, HREADYOUT, HRESP;
	logic [1:0] HTRANS;
	logic [2:0] HSIZE;
	logic [31:0] HADDR, HWDATA, HRDATA, rd;
	sof_fmt_t FORMAT_PINS = '0;
	sof_fmt_t FORMAT_OUT;
	sof_drive_t DRIVE_OUT;
	wire logic HREADY = HREADYOUT;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc = 0;
	always #5 CLK = ~CLK;
	sof_bank DUT (
		.CLK(CLK),
		.RESET(RESET),
		.HSEL(HSEL),
		.HADDR(HADDR),
		.HTRANS(HTRANS),
		.HWRITE(HWRITE),
		.HSIZE(HSIZE),
		.HWDATA(HWDATA),
		.HREADY(HREADY),
		.HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT),
		.HRESP(HRESP),
		.FORMAT_PINS(FORMAT_PINS),
		.FORMAT_OUT(FORMAT_OUT),
		.DRIVE_OUT(DRIVE_OUT)
	);
	sof_host host (
		.CLK(CLK),
		.HREADY(HREADY),
		.HRDATA(HRDATA),
		.HSEL(HSEL),
		.HADDR(HADDR),
		.HTRANS(HTRANS),
		.HWRITE(HWRITE),
		.HSIZE(HSIZE),
		.HWDATA(HWDATA)
	);
	task wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, rd);
	endtask : wr
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		host.xfer(1'b0, a, 32'h0, rd);
		`CHK(rd, e)
	endtask : rdchk
	task wt(input int n);
		repeat (n) @(posedge CLK);
		@(negedge CLK);
	endtask : wt
	task t_defaults;
		`CHK({FORMAT_OUT, DRIVE_OUT}, 18'h0)
		rdchk(SOF_ADDR_FMT, 32'h0);
		rdchk(SOF_ADDR_DRV, 32'h0);
		$display("defaults done");
	endtask : t_defaults
	task t_drive;
		logic [10:0] v;
		for (int i = 0; i < 4; i++)
		begin
			v = {i[0] ? SOF_TERM_166 : SOF_TERM_NONE, 2'(3 - i), 2'(i),
				~i[0], i[0]};
			wr(SOF_ADDR_DRV, {21'h0, v});
			rdchk(SOF_ADDR_DRV, {21'h0, v});
			wt(2);
			`CHK(DRIVE_OUT, sof_drive_t'(v))
			`CHK(DRIVE_OUT.output_drive_current, 2'(i))
		end
		$display("drive done");
	endtask : t_drive
	task t_format;
		logic [10:0] w[6];
		logic [6:0] e[6];
		w = '{11'h4f7, 11'h4f6, 11'h4f5, 11'h422, 11'h453, 11'h485};
		e = '{7'h7f, 7'h34, 7'h75, 7'h10, 7'h2b, 7'h45};
		for (int k = 0; k < 6; k++)
		begin
			wr(SOF_ADDR_FMT, {21'h0, w[k]});
			rdchk(SOF_ADDR_FMT, {21'h0, w[k]});
			wt(2);
			`CHK(FORMAT_OUT, sof_fmt_t'(e[k]))
		end
		rdchk(SOF_ADDR_STAT, 32'h145);
		$display("format done");
	endtask : t_format
	task t_pins;
		logic [6:0] p[2];
		logic [6:0] e[2];
		p = '{7'h2a, 7'h4b};
		e = '{7'h20, 7'h4b};
		wr(SOF_ADDR_FMT, 32'h0f7);
		for (int k = 0; k < 2; k++)
		begin
			@(posedge CLK) FORMAT_PINS <= sof_fmt_t'(p[k]);
			wt(4);
			`CHK(FORMAT_OUT, sof_fmt_t'(e[k]))
		end
		wr(SOF_ADDR_FMT, 32'h4f7);
		wt(2);
		`CHK(FORMAT_OUT, sof_fmt_t'(7'h7f))
		$display("pins done");
	endtask : t_pins
	task t_swrst;
		wr(SOF_ADDR_DRV, 32'h7ff);
		wr(8'h08, 32'h7ff);
		rdchk(8'h08, 32'h0);
		rdchk(SOF_ADDR_DRV, 32'h7ff);
		@(posedge CLK) FORMAT_PINS <= '0;
		wr(SOF_ADDR_CTRL, 32'h400);
		wt(2);
		t_defaults;
		rdchk(SOF_ADDR_CTRL, 32'h0);
		$display("soft reset done");
	endtask : t_swrst
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	// ceiling well above the fewer than 160 cycles the run needs
	always @(posedge CLK)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			tally_and_finish;
		end
	end
	initial
	begin
		repeat (12) @(posedge CLK);
		RESET <= 1'b0;
		wt(0);
		t_defaults;
		t_drive;
		t_format;
		t_pins;
		t_swrst;
		tally_and_finish;
	end
endmodule : serial_output_format_config_tb
`default_nettype wire
